// file: core/cap_cfg_defs.svh
// Offsets, field positions, reset values and counts for the capability and
// configuration register bank. Definitions only; included by bare name.
`ifndef CAP_CFG_DEFS_SVH
`define CAP_CFG_DEFS_SVH

// -----------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------
`define CAP_CFG_OFFSET      32'h0000_0008
`define CAP_ADDR_MSB        31

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define ALERT_MODE_BIT      28
`define OD_SELECT_BIT       23
`define OPER_FREQ_MSB       22
`define OPER_FREQ_LSB       20
`define OD_SUPPORT_BIT      19
`define MAX_FREQ_MSB        18
`define MAX_FREQ_LSB        16
`define WAIT_LIMIT_MSB      15
`define WAIT_LIMIT_LSB      12
`define CHANNEL_MSB         7
`define CHANNEL_LSB         0

// -----------------------------------------------------------------------
// Reset values and encodings
// -----------------------------------------------------------------------
`define ALERT_MODE_RESET    1'b0
`define OD_SELECT_RESET     1'b0
`define OPER_FREQ_RESET     3'h0
`define WAIT_LIMIT_RESET    4'h0
`define FREQ_HIGHEST_CODE   3'h4
`define WAIT_ZERO_MEANS     5'h10

// -----------------------------------------------------------------------
// Serial clocks per byte time
// -----------------------------------------------------------------------
`define SCLK_PER_BYTE_SINGLE 4'h8
`define SCLK_PER_BYTE_DUAL   4'h4
`define SCLK_PER_BYTE_QUAD   4'h2
`define IO_MODE_SINGLE       2'h0
`define IO_MODE_DUAL         2'h1
`define IO_MODE_QUAD         2'h2

`endif

// file: core/cap_cfg_pkg.sv
// Types shared by the capability and configuration register bank.
// Assumes the constants header is available on the include path.
package cap_cfg_pkg;

  // -----------------------------------------------------------------------
  // Alert pin sequencing
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ALERT_IDLE,
    ALERT_SIGNAL,
    ALERT_SERVICED
  } alert_state_t;

  typedef logic [2:0] freq_code_t;
  typedef logic [1:0] io_mode_t;

endpackage : cap_cfg_pkg

// file: core/slave_capability_config_register.sv
// Capability and configuration register of a serial-link slave, reached
// over AHB-Lite, plus the alert pin driver and wait-state budget it steers.
// Assumes mclk is far faster than the serial clock, and that chip select
// and serial clock arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "cap_cfg_defs.svh"

module slave_capability_config_register #(
  parameter logic       OD_SUPPORTED  = 1'b1,
  parameter logic [2:0] MAX_FREQ_CODE = 3'h4,
  parameter logic [7:0] CHANNELS      = 8'h0f
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // AHB-Lite slave port.
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Link side.
  input  wire logic                   csN,
  input  wire logic                   sclk,
  input  wire logic                   inbandReset,
  input  wire cap_cfg_pkg::io_mode_t  ioMode,
  input  wire logic                   alertPending,
  input  wire logic                   waitActive,
  output logic                        waitExhausted,
  output cap_cfg_pkg::freq_code_t     operFreq,
  output logic                        alertOut,
  output logic                        alertOe,
  output logic                        io1AlertOut,
  output logic                        io1AlertOe
);
  import cap_cfg_pkg::*;

  // -----------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------
  logic csMeta_q;
  logic csSync_q;
  logic sclkMeta_q;
  logic sclkSync_q;
  logic sclkPrev_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      csMeta_q   <= 1'b1;
      csSync_q   <= 1'b1;
      sclkMeta_q <= 1'b0;
      sclkSync_q <= 1'b0;
      sclkPrev_q <= 1'b0;
    end else if (ce) begin
      csMeta_q   <= csN;
      csSync_q   <= csMeta_q;
      sclkMeta_q <= sclk;
      sclkSync_q <= sclkMeta_q;
      sclkPrev_q <= sclkSync_q;
    end
  end

  wire sclkRise = sclkSync_q & ~sclkPrev_q;

  // -----------------------------------------------------------------------
  // AHB-Lite address phase capture
  // -----------------------------------------------------------------------
  logic        wrPend_q;
  logic        wrHit_q;

  wire         addrPhase = hsel & htrans[1] & hready;
  wire         regHit    = (haddr == `CAP_CFG_OFFSET);
  wire         wrTake    = addrPhase & hwrite;
  wire         rdTake    = addrPhase & ~hwrite;

  // Single-cycle slave: every transfer completes with no wait state.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrHit_q  <= 1'b0;
    end else if (ce) begin
      wrPend_q <= wrTake;
      wrHit_q  <= wrTake & regHit;
    end
  end

  // -----------------------------------------------------------------------
  // Configuration fields
  // -----------------------------------------------------------------------
  logic       alertMode_q;
  logic       odSelect_q;
  freq_code_t operFreq_q;
  logic [3:0] waitLimit_q;

  wire        regWrite  = wrPend_q & wrHit_q;
  wire freq_code_t freqWr = hwdata[`OPER_FREQ_MSB:`OPER_FREQ_LSB];
  // Reserved frequency codes are refused so the link never leaves the
  // documented set; the previous setting is kept instead.
  wire        freqLegal = (freqWr <= `FREQ_HIGHEST_CODE);
  wire        cfgReset  = rst | inbandReset;

  always_ff @(posedge mclk) begin
    if (cfgReset) begin
      alertMode_q <= `ALERT_MODE_RESET;
      odSelect_q  <= `OD_SELECT_RESET;
      operFreq_q  <= `OPER_FREQ_RESET;
      waitLimit_q <= `WAIT_LIMIT_RESET;
    end else if (ce && regWrite) begin
      alertMode_q <= hwdata[`ALERT_MODE_BIT];
      odSelect_q  <= hwdata[`OD_SELECT_BIT];
      waitLimit_q <= hwdata[`WAIT_LIMIT_MSB:`WAIT_LIMIT_LSB];
      if (freqLegal) begin
        operFreq_q <= freqWr;
      end
    end
  end

  assign operFreq = operFreq_q;

  // -----------------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------------
  logic [31:0] regImage;

  always_comb begin
    regImage = 32'h0000_0000;
    regImage[`ALERT_MODE_BIT] = alertMode_q;
    regImage[`OD_SELECT_BIT]  = odSelect_q;
    regImage[`OPER_FREQ_MSB:`OPER_FREQ_LSB] = operFreq_q;
    regImage[`OD_SUPPORT_BIT] = OD_SUPPORTED;
    // The maximum is a strap of the instance; every lower code is assumed
    // to be supported by the link logic that this register steers.
    regImage[`MAX_FREQ_MSB:`MAX_FREQ_LSB] = MAX_FREQ_CODE;
    regImage[`WAIT_LIMIT_MSB:`WAIT_LIMIT_LSB] = waitLimit_q;
    regImage[`CHANNEL_MSB:`CHANNEL_LSB] = CHANNELS;
  end

  // Data is registered at the address phase so it stands through the
  // data phase; a write to the same word in the previous cycle is not yet seen.
  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && rdTake) begin
      hrdata <= regHit ? regImage : 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------------
  // Wait-state budget
  // -----------------------------------------------------------------------
  logic [3:0] sclkCnt_q;
  logic [4:0] byteCnt_q;
  logic [3:0] sclkPerByte;
  logic [4:0] byteLimit;

  always_comb begin
    case (ioMode)
      `IO_MODE_DUAL: sclkPerByte = `SCLK_PER_BYTE_DUAL;
      `IO_MODE_QUAD: sclkPerByte = `SCLK_PER_BYTE_QUAD;
      default:       sclkPerByte = `SCLK_PER_BYTE_SINGLE;
    endcase
  end

  // A zero limit means the longest budget, one step past the field range.
  assign byteLimit = (waitLimit_q == 4'h0) ? `WAIT_ZERO_MEANS
                                           : {1'b0, waitLimit_q};

  wire byteDone = sclkRise & (sclkCnt_q == sclkPerByte - 4'h1);
  wire budgetHit = (byteCnt_q >= byteLimit);

  always_ff @(posedge mclk) begin
    if (rst || !waitActive) begin
      sclkCnt_q <= 4'h0;
      byteCnt_q <= 5'h00;
    end else if (ce && !budgetHit && sclkRise) begin
      if (byteDone) begin
        sclkCnt_q <= 4'h0;
        byteCnt_q <= byteCnt_q + 5'h01;
      end else begin
        sclkCnt_q <= sclkCnt_q + 4'h1;
      end
    end
  end

  // The link logic must give its final response once this is high.
  assign waitExhausted = waitActive & budgetHit;

  // -----------------------------------------------------------------------
  // Alert signalling
  // -----------------------------------------------------------------------
  alert_state_t alertState_q;
  alert_state_t alertState_d;

  always_comb begin
    alertState_d = alertState_q;
    case (alertState_q)
      ALERT_IDLE: begin
        if (alertPending && csSync_q) begin
          alertState_d = ALERT_SIGNAL;
        end
      end
      ALERT_SIGNAL: begin
        if (!csSync_q) begin
          alertState_d = ALERT_SERVICED;
        end
      end
      ALERT_SERVICED: begin
        if (csSync_q) begin
          alertState_d = ALERT_IDLE;
        end
      end
      default: alertState_d = ALERT_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      alertState_q <= ALERT_IDLE;
    end else if (ce) begin
      alertState_q <= alertState_d;
    end
  end

  // Open-drain needs the select, the dedicated pin and OD_SUPPORTED; with only the
  // select set, the pin stays a driven output so nothing is left floating.
  wire useOpenDrain = alertMode_q & odSelect_q & OD_SUPPORTED;
  wire alertLow     = (alertState_q == ALERT_SIGNAL);

  logic alertOut_q;
  logic alertOe_q;
  logic io1Out_q;
  logic io1Oe_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      alertOut_q <= 1'b1;
      alertOe_q  <= 1'b1;
      io1Out_q   <= 1'b1;
      io1Oe_q    <= 1'b0;
    end else if (ce) begin
      alertOut_q <= ~(alertLow & alertMode_q);
      alertOe_q  <= useOpenDrain ? (alertLow & alertMode_q) : 1'b1;
      io1Out_q   <= 1'b0;
      io1Oe_q    <= alertLow & ~alertMode_q;
    end
  end

  assign alertOut    = alertOut_q;
  assign alertOe     = alertOe_q;
  assign io1AlertOut = io1Out_q;
  assign io1AlertOe  = io1Oe_q;

endmodule : slave_capability_config_register

// file: sim/cap_cfg_asserts.sv
// Concurrent checks on the capability register bank ports.
// Assumes hsel and hready come from a single AHB-Lite master.
`timescale 1ns/1ps
module cap_cfg_asserts
  import cap_cfg_pkg::*;
#(
  parameter logic       OD_SUPPORTED  = 1'b1,
  parameter logic [2:0] MAX_FREQ_CODE = 3'h4,
  parameter logic [7:0] CHANNELS      = 8'h0f
) (
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire logic                    ce,
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic [31:0]             hwdata,
  input wire logic [31:0]             hrdata,
  input wire logic                    csN,
  input wire logic                    inbandReset,
  input wire logic                    alertPending,
  input wire logic                    waitActive,
  input wire logic                    waitExhausted,
  input wire cap_cfg_pkg::freq_code_t operFreq,
  input wire logic                    alertOut,
  input wire logic                    alertOe,
  input wire logic                    io1AlertOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire take = hsel && htrans[1] && hready && ce;
  wire hit = haddr == 32'h0000_0008;
  sequence wr_addr; take && hwrite && hit; endsequence
  sequence rd_addr; take && !hwrite; endsequence
  sequence cs_held; (!csN && ce) [*8]; endsequence
  sequence alert_wanted; (csN && alertPending && ce) [*8]; endsequence
  a_freq_store: assert property (wr_addr ##1 (ce && !inbandReset &&
    hwdata[22:20] <= 3'h4) |=> operFreq == $past(hwdata[22:20]))
    else $error("frequency write not stored");
  a_freq_refuse: assert property (wr_addr ##1 (ce &&
    hwdata[22:20] > 3'h4) |=> $stable(operFreq))
    else $error("reserved frequency code stored");
  a_freq_reset: assert property ($fell(rst) |-> operFreq == 3'h0)
    else $error("frequency not zero after reset");
  a_inband_clear: assert property (inbandReset && ce |=>
    operFreq == 3'h0) else $error("in-band reset missed frequency");
  a_fixed_fields: assert property (rd_addr ##0 hit |=>
    hrdata[19:16] == {OD_SUPPORTED, MAX_FREQ_CODE} && hrdata[11:8] == 4'h0
    && hrdata[7:0] == CHANNELS && hrdata[22:20] == operFreq)
    else $error("read-only fields wrong");
  a_unmapped_zero: assert property (rd_addr ##0 !hit |=>
    hrdata == 32'h0) else $error("unmapped read not zero");
  a_wait_idle: assert property ((!waitActive && ce) [*2] |->
    !waitExhausted) else $error("budget used up while idle");
  a_cs_release: assert property (cs_held |-> !io1AlertOe &&
    (alertOut || !alertOe)) else $error("alert held during select");
  a_alert_raise: assert property (alert_wanted |-> io1AlertOe ||
    (alertOe && !alertOut)) else $error("alert not signalled");
endmodule : cap_cfg_asserts
bind slave_capability_config_register cap_cfg_asserts #(
  .OD_SUPPORTED(OD_SUPPORTED), .MAX_FREQ_CODE(MAX_FREQ_CODE),
  .CHANNELS(CHANNELS)) chk (.mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .csN(csN), .inbandReset(inbandReset),
  .alertPending(alertPending), .waitActive(waitActive),
  .waitExhausted(waitExhausted), .operFreq(operFreq), .alertOut(alertOut),
  .alertOe(alertOe), .io1AlertOe(io1AlertOe));

// file: sim/link_master_model.sv
// Link master model driving chip select and the serial clock.
// The clock idles low and runs only inside frames, 160 ns period.
`timescale 1ns/1ps
module link_master_model (
  output logic csN,
  output logic sclk
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
  end
  task automatic select(input logic level);
    csN = level;
  endtask : select
  // The odd offset keeps link edges off the system clock edges.
  task automatic frame(input int n);
    #1.3;
    csN = 1'b0;
    #80;
    repeat (n) begin
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
      #80;
    end
    csN = 1'b1;
    #80;
  endtask : frame
endmodule : link_master_model

// file: sim/tb_slave_capability_config_register.sv
// Self-checking bench for the capability register bank.
// Uses the link master model and the bound checker.
`timescale 1ns/1ps
module tb_slave_capability_config_register;
  import cap_cfg_pkg::*;
  localparam logic [7:0] CH = 8'h0b;
  logic mclk, rst, hwrite, inbandReset, alertPending, waitActive;
  logic [31:0] haddr, hwdata, hrdata, rd, d;
  logic [1:0] htrans;
  io_mode_t ioMode;
  freq_code_t operFreq;
  logic hreadyout, hresp, waitExhausted, alertOut, alertOe;
  logic io1AlertOut, io1AlertOe, csN, sclk, am, od, ce;
  logic [2:0] fq;
  logic [3:0] wl;
  int seed = 85015;
  int miscompares, checks_done, cyc;
  slave_capability_config_register #(.CHANNELS(CH)) DUT (
    .mclk(mclk), .rst(rst), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .csN(csN), .sclk(sclk), .inbandReset(inbandReset), .ioMode(ioMode),
    .alertPending(alertPending), .waitActive(waitActive),
    .waitExhausted(waitExhausted), .operFreq(operFreq), .alertOut(alertOut),
    .alertOe(alertOe), .io1AlertOut(io1AlertOut), .io1AlertOe(io1AlertOe));
  link_master_model link (.csN(csN), .sclk(sclk));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [31:0] a, wd);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : bus
  function automatic logic [31:0] word_of();
    return {3'h0, am, 4'h0, od, fq, 1'b1, 3'h4, wl, 4'h0, CH};
  endfunction : word_of
  function automatic int sclks_for(input int m);
    return (wl == 4'h0 ? 16 : int'(wl)) * (8 >> ((m == 3) ? 2 : m));
  endfunction : sclks_for
  function automatic logic [2:0] pins();
    return {alertOut | ~alertOe, alertOe, io1AlertOe};
  endfunction : pins
  task automatic wr(input logic [31:0] v);
    bus(1'b1, 32'h8, v);
    am = v[28];
    od = v[23];
    wl = v[15:12];
    if (v[22:20] <= 3'h4) fq = v[22:20];
  endtask : wr
  task automatic rdchk();
    bus(1'b0, 32'h8, 32'h0);
    check(rd, word_of());
  endtask : rdchk
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {htrans, haddr, hwrite, hwdata, ioMode} = '0;
    {inbandReset, alertPending, waitActive, am, od, fq, wl} = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdchk();
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      d[22:20] = (i < 8) ? i[2:0] : d[22:20] % 3'h5;
      wr(d);
      rdchk();
    end
    bus(1'b1, 32'hc, 32'hffff_ffff);
    bus(1'b0, 32'hc, 32'h0);
    check(rd, 32'h0);
    rdchk();
    wr(32'hffff_ffff);
    @(posedge mclk);
    inbandReset <= 1'b1;
    @(posedge mclk);
    inbandReset <= 1'b0;
    {am, od, fq, wl} = '0;
    rdchk();
    // With the clock enable low the bank must ignore a whole write.
    ce <= 1'b0;
    bus(1'b1, 32'h8, 32'h1043_f000);
    ce <= 1'b1;
    rdchk();
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wr({16'h0, (m == 3) ? 4'h0 : 4'(m + 1), 12'h0});
      ioMode <= (m == 3) ? 2'h2 : 2'(m);
      waitActive <= 1'b1;
      link.frame(sclks_for(m) - 1);
      repeat (8) @(posedge mclk);
      check(waitExhausted, 1'b0);
      link.frame(1);
      repeat (8) @(posedge mclk);
      check(waitExhausted, 1'b1);
      waitActive <= 1'b0;
      repeat (4) @(posedge mclk);
      check(waitExhausted, 1'b0);
    end
    $display("test wait budget done");
    for (int k = 0; k < 3; k++) begin
      wr({3'h0, k > 0, 4'h0, k != 1, 23'h0});
      alertPending <= 1'b1;
      repeat (12) @(posedge mclk);
      check(pins(), am ? 3'b010 : 3'b111);
      link.select(1'b0);
      repeat (12) @(posedge mclk);
      check(pins(), (am && od) ? 3'b100 : 3'b110);
      alertPending <= 1'b0;
      link.select(1'b1);
      repeat (12) @(posedge mclk);
    end
    $display("test alert done");
    wrap_up();
  end
endmodule : tb_slave_capability_config_register
